// [rpt_pkg.sv]
// Constants, types and helpers for the read prefetch and timer status block
// ****************************************************************************
// ****************************************************************************
package rpt_pkg;

	// ************************************************************************
	// Register map
	// ************************************************************************
	localparam int                   CFG_ADDR_W          = 12;
	localparam logic [CFG_ADDR_W-1:0] TIMER_STATUS_OFFSET = 12'h0b8;
	localparam logic [CFG_ADDR_W-1:0] PREFETCH_CTRL_OFFSET = 12'h0bc;
	localparam logic [31:0]          TIMER_STATUS_RESET  = 32'h00000000;
	localparam logic [31:0]          PREFETCH_CTRL_RESET = 32'h03000041;
	localparam logic [31:0]          PREFETCH_CTRL_MASK  = 32'h07ffffff;
	localparam int                   DISCARD_BIT         = 2;
	localparam int                   RETRY_BIT           = 0;

	// ************************************************************************
	// Prefetch sizes
	// ************************************************************************
	localparam int          THRESH_W        = 6;
	localparam int          SIZE_W          = 13;
	localparam logic [12:0] CHUNK_BYTES     = 13'h0040;
	localparam logic [12:0] DWORD_BYTES     = 13'h0004;
	localparam logic [12:0] QWORD_BYTES     = 13'h0008;
	localparam logic [12:0] CACHELINE_BYTES = 13'h0040;

	// ************************************************************************
	// Types
	// ************************************************************************
	typedef enum logic [1:0] {
		RPT_CMD_READ,
		RPT_CMD_LINE,
		RPT_CMD_MULT
	} rpt_cmd_type;

	// Prefetch control register layout, bit 31 first
	typedef struct packed {
		logic [4:0]          reserved;
		logic                plain_read_prefetch_sel;
		logic                line_read_prefetch_sel;
		logic                multiple_read_prefetch_sel;
		logic [THRESH_W-1:0] line_read_thresh_fast;
		logic [THRESH_W-1:0] line_read_thresh_slow;
		logic [THRESH_W-1:0] multiple_read_thresh_fast;
		logic [THRESH_W-1:0] multiple_read_thresh_slow;
	} rpt_ctrl_type;

	// Configuration access from the bridge's config decoder
	typedef struct packed {
		logic                  wr;
		logic                  rd;
		logic [CFG_ADDR_W-1:0] addr;
		logic [3:0]            be;
		logic [31:0]           wdata;
	} rpt_cfg_req_type;

	// Memory read command seen from the PCI master
	typedef struct packed {
		logic        valid;
		rpt_cmd_type cmd;
		logic        fast;
		logic        wide;
	} rpt_read_req_type;

	// Prefetch size handed to the read datapath
	typedef struct packed {
		logic              valid;
		rpt_cmd_type       cmd;
		logic [SIZE_W-1:0] bytes;
	} rpt_prefetch_type;

	// Threshold code n means n+1 chunks of 64 bytes
	function automatic logic [SIZE_W-1:0] chunk_bytes(
		input logic [THRESH_W-1:0] code
	);
		chunk_bytes = 13'({7'h00, code} + 13'h0001) * CHUNK_BYTES;
	endfunction

endpackage

// [rpt_size_sel.sv]
// Prefetch size selection for one memory read command
module rpt_size_sel (
	// Settings
	input  wire rpt_pkg::rpt_ctrl_type ctrl,
	// Command
	input  wire rpt_pkg::rpt_cmd_type  cmd,
	input  wire logic                  fast,
	input  wire logic                  wide,
	// Result
	output logic [rpt_pkg::SIZE_W-1:0] bytes
);

	logic [rpt_pkg::THRESH_W-1:0] line_code;
	logic [rpt_pkg::THRESH_W-1:0] mult_code;

	// Bus speed picks which threshold field applies
	always_comb begin
		line_code = fast ? ctrl.line_read_thresh_fast
			: ctrl.line_read_thresh_slow;
		mult_code = fast ? ctrl.multiple_read_thresh_fast
			: ctrl.multiple_read_thresh_slow;
	end

	// Size per command and select bit
	always_comb begin
		case (cmd)
			rpt_pkg::RPT_CMD_READ: begin
				if (ctrl.plain_read_prefetch_sel) begin
					bytes = rpt_pkg::chunk_bytes(line_code);
				end else begin
					bytes = wide ? rpt_pkg::QWORD_BYTES
						: rpt_pkg::DWORD_BYTES;
				end
			end
			rpt_pkg::RPT_CMD_LINE: begin
				bytes = ctrl.line_read_prefetch_sel
					? rpt_pkg::chunk_bytes(line_code)
					: rpt_pkg::CACHELINE_BYTES;
			end
			rpt_pkg::RPT_CMD_MULT: begin
				bytes = ctrl.multiple_read_prefetch_sel
					? rpt_pkg::chunk_bytes(mult_code)
					: 13'(rpt_pkg::CACHELINE_BYTES << 1);
			end
			default: begin
				bytes = rpt_pkg::DWORD_BYTES;
			end
		endcase
	end

endmodule

// [rpt_regs.sv]
// Timer status and read prefetch control registers with size selection
module rpt_regs (
	// Clock and reset
	input  wire logic                      mclk,
	input  wire logic                      resetn,
	// Configuration access
	input  wire rpt_pkg::rpt_cfg_req_type  cfg_req,
	output logic                           cfg_ack,
	output logic [31:0]                    cfg_rdata,
	// Timer expiry levels from the secondary timers
	input  wire logic                      discard_timer_expired,
	input  wire logic                      retry_timer_expired,
	// Memory read commands and resulting prefetch size
	input  wire rpt_pkg::rpt_read_req_type read_req,
	output rpt_pkg::rpt_prefetch_type      prefetch
);

	// ************************************************************************
	// State
	// ************************************************************************
	rpt_pkg::rpt_ctrl_type     ctrl;
	rpt_pkg::rpt_ctrl_type     next_ctrl;
	logic [31:0]               status;
	logic [31:0]               next_status;
	logic                      next_cfg_ack;
	logic [31:0]               next_cfg_rdata;
	rpt_pkg::rpt_prefetch_type next_prefetch;
	logic [rpt_pkg::SIZE_W-1:0] sel_bytes;
	logic                      hit_status;
	logic                      hit_ctrl;

	// ************************************************************************
	// Address decode
	// ************************************************************************
	// Only whole aligned words are decoded; low two bits must be zero
	always_comb begin
		hit_status = (cfg_req.addr == rpt_pkg::TIMER_STATUS_OFFSET);
		hit_ctrl   = (cfg_req.addr == rpt_pkg::PREFETCH_CTRL_OFFSET);
	end

	// ************************************************************************
	// Prefetch control register
	// ************************************************************************
	// Byte-lane write; reserved bits forced to zero
	always_comb begin
		logic [31:0] word;
		word = ctrl;
		if (cfg_req.wr && hit_ctrl) begin
			for (int i = 0; i < 4; i++) begin
				if (cfg_req.be[i]) begin
					word[i*8 +: 8] = cfg_req.wdata[i*8 +: 8];
				end
			end
		end
		next_ctrl = word & rpt_pkg::PREFETCH_CTRL_MASK;
	end

	// Register the control word
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ctrl <= rpt_pkg::PREFETCH_CTRL_RESET;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// ************************************************************************
	// Timer status register
	// ************************************************************************
	// Live expiry levels, sampled each cycle; writes have no effect
	always_comb begin
		next_status                       = rpt_pkg::TIMER_STATUS_RESET;
		next_status[rpt_pkg::DISCARD_BIT] = discard_timer_expired;
		next_status[rpt_pkg::RETRY_BIT]   = retry_timer_expired;
	end

	// Register the status word
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			status <= rpt_pkg::TIMER_STATUS_RESET;
		end else begin
			status <= next_status;
		end
	end

	// ************************************************************************
	// Configuration answer
	// ************************************************************************
	// Every access is answered one cycle later; unmapped reads give zero
	always_comb begin
		next_cfg_ack   = cfg_req.wr | cfg_req.rd;
		next_cfg_rdata = 32'h00000000;
		if (cfg_req.rd) begin
			if (hit_status) begin
				next_cfg_rdata = status;
			end else if (hit_ctrl) begin
				next_cfg_rdata = ctrl;
			end
		end
	end

	// Register the answer
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cfg_ack   <= 1'b0;
			cfg_rdata <= 32'h00000000;
		end else begin
			cfg_ack   <= next_cfg_ack;
			cfg_rdata <= next_cfg_rdata;
		end
	end

	// ************************************************************************
	// Prefetch size
	// ************************************************************************
	// Size uses the settings in force in the cycle the command arrives
	rpt_size_sel u_size_sel (
		.ctrl  (ctrl),
		.cmd   (read_req.cmd),
		.fast  (read_req.fast),
		.wide  (read_req.wide),
		.bytes (sel_bytes)
	);

	// Capture the answer for the read datapath
	always_comb begin
		next_prefetch.valid = read_req.valid;
		next_prefetch.cmd   = read_req.cmd;
		next_prefetch.bytes = read_req.valid ? sel_bytes
			: '0;
	end

	// Register the prefetch answer
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			prefetch <= '0;
		end else begin
			prefetch <= next_prefetch;
		end
	end

	// ************************************************************************
	// Checks
	// ************************************************************************
	default clocking chk_clk @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	ctrl_after_reset_a: assert property (
		$past(!resetn) |-> ctrl == rpt_pkg::PREFETCH_CTRL_RESET
	) else $error("control word not at reset value after reset");

	discard_status_a: assert property (
		discard_timer_expired ##2 (cfg_req.rd && hit_status) |=>
			cfg_rdata[rpt_pkg::DISCARD_BIT] == $past(status[2])
			&& $past(status[2]) == $past(discard_timer_expired, 2)
	) else $error("discard expiry not shown on status bit");

	retry_status_a: assert property (
		($past(resetn) && cfg_req.rd && hit_status) |=>
			cfg_rdata[rpt_pkg::RETRY_BIT] == $past(retry_timer_expired, 2)
	) else $error("retry expiry not shown on status bit");

	status_reserved_a: assert property (
		(cfg_req.rd && hit_status) |=> cfg_rdata[31:3] == 29'h0
			&& !cfg_rdata[1]
	) else $error("status reserved bits not zero");

	ctrl_reserved_a: assert property (
		(cfg_req.rd && hit_ctrl) |=> cfg_rdata[31:27] == 5'h00
			&& cfg_rdata == $past(ctrl)
	) else $error("control readback wrong");

	ctrl_write_a: assert property (
		(cfg_req.wr && hit_ctrl && cfg_req.be[2]) |=>
			ctrl.line_read_thresh_fast == $past(cfg_req.wdata[23:18])
	) else $error("fast line threshold not written");

	plain_dword_a: assert property (
		(read_req.valid && read_req.cmd == rpt_pkg::RPT_CMD_READ
			&& !ctrl.plain_read_prefetch_sel && !read_req.wide) |=>
			prefetch.valid && prefetch.bytes == 13'h0004
	) else $error("plain read not one dword");

	line_one_a: assert property (
		(read_req.valid && read_req.cmd == rpt_pkg::RPT_CMD_LINE
			&& !ctrl.line_read_prefetch_sel) |=>
			prefetch.bytes == 13'h0040
	) else $error("read line not one cacheline");

	mult_two_a: assert property (
		(read_req.valid && read_req.cmd == rpt_pkg::RPT_CMD_MULT
			&& !ctrl.multiple_read_prefetch_sel) |=>
			prefetch.bytes == 13'h0080
	) else $error("read multiple not two cachelines");

	slow_line_a: assert property (
		(read_req.valid && read_req.cmd == rpt_pkg::RPT_CMD_LINE
			&& ctrl.line_read_prefetch_sel && !read_req.fast) |=>
			prefetch.bytes == ({7'h00, $past(ctrl.line_read_thresh_slow)}
				+ 13'h0001) * 13'h0040
	) else $error("slow line threshold size wrong");

	fast_mult_a: assert property (
		(read_req.valid && read_req.cmd == rpt_pkg::RPT_CMD_MULT
			&& ctrl.multiple_read_prefetch_sel && read_req.fast) |=>
			prefetch.bytes == ({7'h00,
				$past(ctrl.multiple_read_thresh_fast)} + 13'h0001)
				* 13'h0040
	) else $error("fast multiple threshold size wrong");

	slow_mult_a: assert property (
		(read_req.valid && read_req.cmd == rpt_pkg::RPT_CMD_MULT
			&& ctrl.multiple_read_prefetch_sel && !read_req.fast) |=>
			prefetch.bytes == ({7'h00,
				$past(ctrl.multiple_read_thresh_slow)} + 13'h0001)
				* 13'h0040
	) else $error("slow multiple threshold size wrong");

	idle_quiet_a: assert property (
		!read_req.valid |=> !prefetch.valid && prefetch.bytes == 13'h0000
	) else $error("prefetch answer without command");

	fast_line_a: assert property (
		(read_req.valid && read_req.cmd == rpt_pkg::RPT_CMD_LINE
			&& ctrl.line_read_prefetch_sel && read_req.fast) |=>
			prefetch.bytes == ({7'h00,
				$past(ctrl.line_read_thresh_fast)} + 13'h0001)
				* 13'h0040
	) else $error("fast line threshold size wrong");

	plain_fast_a: assert property (
		(read_req.valid && read_req.cmd == rpt_pkg::RPT_CMD_READ
			&& ctrl.plain_read_prefetch_sel && read_req.fast) |=>
			prefetch.bytes == ({7'h00,
				$past(ctrl.line_read_thresh_fast)} + 13'h0001)
				* 13'h0040
	) else $error("plain read fast threshold size wrong");

	plain_slow_a: assert property (
		(read_req.valid && read_req.cmd == rpt_pkg::RPT_CMD_READ
			&& ctrl.plain_read_prefetch_sel && !read_req.fast) |=>
			prefetch.bytes == ({7'h00,
				$past(ctrl.line_read_thresh_slow)} + 13'h0001)
				* 13'h0040
	) else $error("plain read slow threshold size wrong");

	plain_qword_a: assert property (
		(read_req.valid && read_req.cmd == rpt_pkg::RPT_CMD_READ
			&& !ctrl.plain_read_prefetch_sel && read_req.wide) |=>
			prefetch.valid && prefetch.bytes == 13'h0008
	) else $error("wide plain read not two dwords");

	cmd_echo_a: assert property (
		read_req.valid |=> prefetch.valid
			&& prefetch.cmd == $past(read_req.cmd)
	) else $error("prefetch answer lost or command not echoed");

	cfg_ack_a: assert property (
		(cfg_req.wr || cfg_req.rd) |=> cfg_ack
	) else $error("config access not acknowledged");

	cfg_quiet_a: assert property (
		!(cfg_req.wr || cfg_req.rd) |=> !cfg_ack
	) else $error("acknowledge without config access");

	rdata_zero_a: assert property (
		!cfg_req.rd |=> cfg_rdata == 32'h00000000
	) else $error("read data not zero outside a read answer");

	unmapped_read_a: assert property (
		(cfg_req.rd && !hit_status && !hit_ctrl) |=>
			cfg_rdata == 32'h00000000
	) else $error("unmapped offset read not zero");

	status_live_a: assert property (
		$past(resetn) |-> status == {29'h0,
			$past(discard_timer_expired), 1'b0,
			$past(retry_timer_expired)}
	) else $error("status word not tracking timer levels");

	ctrl_hold_a: assert property (
		!(cfg_req.wr && hit_ctrl) |=> ctrl == $past(ctrl)
	) else $error("control word changed without a write");

	ctrl_full_write_a: assert property (
		(cfg_req.wr && hit_ctrl && cfg_req.be == 4'hf) |=>
			ctrl == ($past(cfg_req.wdata) & 32'h07ffffff)
	) else $error("full control write not masked");

	ctrl_sel_write_a: assert property (
		(cfg_req.wr && hit_ctrl && cfg_req.be[3]) |=>
			{ctrl.plain_read_prefetch_sel, ctrl.line_read_prefetch_sel,
				ctrl.multiple_read_prefetch_sel}
				== $past(cfg_req.wdata[26:24])
	) else $error("prefetch select bits not written");

	lane0_write_a: assert property (
		(cfg_req.wr && hit_ctrl && cfg_req.be[0]) |=>
			ctrl.multiple_read_thresh_slow == $past(cfg_req.wdata[5:0])
	) else $error("slow multiple threshold not written");

endmodule

// [rpt_pci_master.sv]
// PCI master model that issues memory read commands to the bridge
module rpt_pci_master (
	// Clock
	input  wire logic                 mclk,
	// Command toward the bridge
	output rpt_pkg::rpt_read_req_type read_req
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle, no command pending
	initial begin
		read_req = '0;
	end

	// One command for one cycle; qualifiers scrambled once released
	task automatic issue(input rpt_pkg::rpt_cmd_type cmd,
		input logic fast, input logic wide);
		@(posedge mclk);
		read_req <= {1'b1, cmd, fast, wide};
		@(posedge mclk);
		read_req <= {1'b0, ~{cmd, fast, wide}};
	endtask
endmodule

// [read_prefetch_and_timer_status_tb.sv]
// Self-checking bench for the timer status and prefetch registers
module read_prefetch_and_timer_status_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************************
	// Signals and instances
	// ************************************************************************
	logic                      mclk    = 1'b0;
	logic                      resetn  = 1'b0;
	rpt_pkg::rpt_cfg_req_type  cfg_req = '0;
	logic                      cfg_ack;
	logic [31:0]               cfg_rdata;
	logic                      dis_exp = 1'b0;
	logic                      ret_exp = 1'b0;
	rpt_pkg::rpt_read_req_type read_req;
	rpt_pkg::rpt_prefetch_type prefetch;
	int                        err_count = 0;
	int                        tests_run = 0;
	logic [31:0]               rd;

	// Free-running clock
	always #5 mclk = ~mclk;

	rpt_regs u_dut (
		.mclk                  (mclk),
		.resetn                (resetn),
		.cfg_req               (cfg_req),
		.cfg_ack               (cfg_ack),
		.cfg_rdata             (cfg_rdata),
		.discard_timer_expired (dis_exp),
		.retry_timer_expired   (ret_exp),
		.read_req              (read_req),
		.prefetch              (prefetch)
	);

	rpt_pci_master u_mst (
		.mclk     (mclk),
		.read_req (read_req)
	);

	// ************************************************************************
	// Shared tasks
	// ************************************************************************
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One config access, answer checked just after the taking edge
	task automatic cfg(input logic w, input logic [11:0] a,
		input logic [3:0] be, input logic [31:0] d);
		@(posedge mclk);
		cfg_req <= {w, ~w, a, be, d};
		@(posedge mclk);
		cfg_req <= {2'b00, ~a, 4'h0, ~d};
		#1;
		chk(32'(cfg_ack), 32'h1);
		rd = cfg_rdata;
	endtask

	// Read one offset and compare
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		cfg(1'b0, a, 4'h0, 32'h0);
		chk(rd, exp);
	endtask

	// One read command and its prefetch answer
	task automatic pf(input rpt_pkg::rpt_cmd_type c, input logic f,
		input logic w, input logic [12:0] exp);
		logic [31:0] seen;
		u_mst.issue(c, f, w);
		#1;
		seen = {16'h0, prefetch.valid, prefetch.cmd, prefetch.bytes};
		chk(seen, {16'h0, 1'b1, c, exp});
	endtask

	// Counts, verdict and end of run
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ************************************************************************
	// Scenarios
	// ************************************************************************
	// Reset values, unmapped offset and default sizes
	task automatic test_reset;
		rchk(12'h0bc, 32'h03000041);
		rchk(12'h0b8, 32'h00000000);
		rchk(12'h0c0, 32'h00000000);
		pf(rpt_pkg::RPT_CMD_MULT, 1'b0, 1'b0, 13'h0080);
		pf(rpt_pkg::RPT_CMD_MULT, 1'b1, 1'b0, 13'h0080);
		pf(rpt_pkg::RPT_CMD_LINE, 1'b0, 1'b0, 13'h0040);
		pf(rpt_pkg::RPT_CMD_LINE, 1'b1, 1'b0, 13'h0040);
		pf(rpt_pkg::RPT_CMD_READ, 1'b0, 1'b0, 13'h0004);
		pf(rpt_pkg::RPT_CMD_READ, 1'b1, 1'b1, 13'h0008);
		$display("test reset done");
	endtask

	// Timer levels on status bits, status ignores writes
	task automatic test_status;
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			dis_exp <= i[1];
			ret_exp <= i[0];
			cfg(1'b1, 12'h0b8, 4'hf, 32'hffffffff);
			rchk(12'h0b8, {29'h0, i[1], 1'b0, i[0]});
		end
		$display("test status done");
	endtask

	// Reserved bits and byte lanes of the control word
	task automatic test_reserved;
		cfg(1'b1, 12'h0bc, 4'hf, 32'hffffffff);
		rchk(12'h0bc, 32'h07ffffff);
		cfg(1'b1, 12'h0bc, 4'h1, 32'h00000000);
		rchk(12'h0bc, 32'h07ffff00);
		$display("test reserved done");
	endtask

	// Select bits cleared: fixed sizes despite set thresholds
	task automatic test_sel_off;
		cfg(1'b1, 12'h0bc, 4'hf, 32'h00ffffff);
		pf(rpt_pkg::RPT_CMD_LINE, 1'b1, 1'b0, 13'h0040);
		pf(rpt_pkg::RPT_CMD_MULT, 1'b0, 1'b0, 13'h0080);
		pf(rpt_pkg::RPT_CMD_READ, 1'b1, 1'b0, 13'h0004);
		$display("test select off done");
	endtask

	// Distinct codes per field, speed picks the field
	task automatic test_thresh;
		cfg(1'b1, 12'h0bc, 4'hf, 32'h07fc5080);
		pf(rpt_pkg::RPT_CMD_READ, 1'b1, 1'b0, 13'h1000);
		pf(rpt_pkg::RPT_CMD_READ, 1'b0, 1'b0, 13'h0180);
		pf(rpt_pkg::RPT_CMD_LINE, 1'b1, 1'b0, 13'h1000);
		pf(rpt_pkg::RPT_CMD_LINE, 1'b0, 1'b0, 13'h0180);
		pf(rpt_pkg::RPT_CMD_MULT, 1'b1, 1'b0, 13'h00c0);
		pf(rpt_pkg::RPT_CMD_MULT, 1'b0, 1'b0, 13'h0040);
		$display("test thresholds done");
	endtask

	// ************************************************************************
	// Main sequence and watchdog
	// ************************************************************************
	// Reset for 8 cycles, then each scenario in turn
	initial begin
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		test_reset();
		test_status();
		test_reserved();
		test_sel_off();
		test_thresh();
		finish_test();
	end

	// Cut a hang short
	initial begin
		repeat (5000) @(posedge mclk);
		err_count++;
		finish_test();
	end
endmodule
